// [include/io_read_watchdog_defs.vh]
// constants for the io read watchdog: port addresses and timeout counts
// assumes a 100 MHz system clock and a 16-bit host i/o address
`ifndef IO_READ_WATCHDOG_DEFS_VH
`define IO_READ_WATCHDOG_DEFS_VH

// ****************************************************************
// port addresses
// ****************************************************************
`define WD_ADDR_W          16
`define WD_PORT_KICK       16'h0443
`define WD_PORT_STOP       16'h0043

// ****************************************************************
// timing
// ****************************************************************
`define WD_CLK_MHZ         100
`define WD_TIMEOUT_MS      1600
// nominal timeout in system clock cycles, 1600 ms * 100000 cycles per ms
`define WD_TIMEOUT_CYC     28'h989_6800
`define WD_CNT_W           28
// width of the reset pulse sent to the cpu
`define WD_RST_PULSE_CYC   5'h10
`define WD_RST_CNT_W       5

// ****************************************************************
// read data
// ****************************************************************
// value returned on a watchdog port read, and its value during reset
`define WD_RD_DATA         8'hff
`define WD_RD_DATA_RST     8'h00

`endif

// [src/wd_sync2.v]
// two-flop synchroniser for one level from outside the clock domain
// assumes clk_sys is the only clock; first flop is read by the second only
`timescale 1ns/100ps
module wd_sync2 (
   clk_sys,
   nrst,
   din,
   dout
);
   input  wire clk_sys;
   input  wire nrst;
   input  wire din;
   output reg  dout;

   reg meta_q;

   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         meta_q <= 1'b0;
         dout   <= 1'b0;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule

// [src/io_read_watchdog.v]
// io read watchdog: armed, restarted and disarmed by host i/o reads
// assumes host read strobe and address come from pins outside clk_sys
//
// What this block and its host must do
// R01: first read of 0x443 arms watchdog
// R02: each armed 0x443 read restarts count
// R03: armed timeout without restart resets cpu
// R04: read of 0x043 disarms, no reset; a read on the expire cycle still resets the cpu
// R05: real timeout may vary plus/minus thirty percent
// R06: host restarts about once per second
// R07: read data meaningless, only read matters
`timescale 1ns/100ps
`include "io_read_watchdog_defs.vh"
module io_read_watchdog #(
   parameter [`WD_CNT_W-1:0] TIMEOUT_CYC = `WD_TIMEOUT_CYC
) (
   clk_sys,
   nrst,
   io_rd_n,
   io_addr,
   cpu_rst_n,
   armed,
   rd_data,
   rd_data_oe
);
   input  wire                   clk_sys;
   input  wire                   nrst;
   input  wire                   io_rd_n;
   input  wire [`WD_ADDR_W-1:0]  io_addr;
   output reg                    cpu_rst_n;
   output reg                    armed;
   output reg  [7:0]             rd_data;
   output reg                    rd_data_oe;

   // ****************************************************************
   // pin synchronisation
   // ****************************************************************
   wire                  rd_s;
   wire [`WD_ADDR_W-1:0] addr_s;
   reg                   rd_prev_q;
   wire                  rd_start;
   reg                   hit_kick;
   reg                   hit_stop;
   reg                   port_hit;
   genvar                gi;

   // the pin strobe is active low; the synchroniser hands it on active high
   wd_sync2 u_rd_sync (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .din     (~io_rd_n),
      .dout    (rd_s)
   );

   // address is stable for the whole strobe, so one flop pair per bit
   // lands it on the same edge as the synced strobe
   generate
      for (gi = 0; gi < `WD_ADDR_W; gi = gi + 1) begin : g_addr_sync
         wd_sync2 u_addr_sync (
            .clk_sys (clk_sys),
            .nrst    (nrst),
            .din     (io_addr[gi]),
            .dout    (addr_s[gi])
         );
      end
   endgenerate

   // ****************************************************************
   // read cycle decode
   // ****************************************************************
   // idle level of the synced strobe is low, so no false edge after reset
   // limitation: a strobe shorter than one clock may be missed
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rd_prev_q <= 1'b0;
      end else begin
         rd_prev_q <= rd_s;
      end
   end

   // one event per read cycle, taken at the start of the strobe
   assign rd_start = rd_s & ~rd_prev_q; // R07

   // only the two watchdog ports decode; every other address is ignored
   always @* begin
      hit_kick = 1'b0;
      hit_stop = 1'b0;
      port_hit = 1'b0;
      case (addr_s)
         `WD_PORT_KICK: begin
            hit_kick = rd_start;
            port_hit = 1'b1;
         end
         `WD_PORT_STOP: begin
            hit_stop = rd_start;
            port_hit = 1'b1;
         end
         default: begin
            // reads of any other port belong to other devices
            port_hit = 1'b0;
         end
      endcase
   end

   // ****************************************************************
   // arm state and timeout count
   // ****************************************************************
   // off: disarmed, count held at zero
   // run: armed, counting up to the timeout
   localparam [1:0] ST_OFF = 2'h1;
   localparam [1:0] ST_RUN = 2'h2;

   reg [1:0]               state_q;
   reg [1:0]               state_d;
   reg [`WD_CNT_W-1:0]     cnt_q;
   reg [`WD_CNT_W-1:0]     cnt_d;
   wire                    expire;

   // the count is exact, so the period sits at nominal, well inside
   // the thirty percent spread; a slower board clock only stretches it
   assign expire = (state_q == ST_RUN) & (cnt_q == TIMEOUT_CYC - 1'b1); // R05

   always @* begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         ST_OFF: begin
            cnt_d = {`WD_CNT_W{1'b0}};
            if (hit_kick) begin
               state_d = ST_RUN; // R01
            end
         end
         ST_RUN: begin
            // stop outranks kick, though both cannot land in one cycle
            if (hit_stop) begin
               state_d = ST_OFF; // R04
               cnt_d   = {`WD_CNT_W{1'b0}};
            end else if (hit_kick) begin
               cnt_d   = {`WD_CNT_W{1'b0}}; // R02
            end else if (expire) begin
               // the cpu restarts from scratch, so the watchdog drops back too
               state_d = ST_OFF; // R03
               cnt_d   = {`WD_CNT_W{1'b0}};
            end else begin
               cnt_d   = cnt_q + 1'b1;
            end
         end
         default: begin
            state_d = ST_OFF;
            cnt_d   = {`WD_CNT_W{1'b0}};
         end
      endcase
   end

   // state and count move together
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_q <= ST_OFF;
         cnt_q   <= {`WD_CNT_W{1'b0}};
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // armed is taken from the next state so it changes with state_q
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         armed <= 1'b0;
      end else begin
         armed <= (state_d == ST_RUN);
      end
   end

   // ****************************************************************
   // cpu reset pulse
   // ****************************************************************
   reg [`WD_RST_CNT_W-1:0] pulse_q;
   reg [`WD_RST_CNT_W-1:0] pulse_d;
   reg                     cpu_rst_n_d;
   wire                    pulse_last;

   // the pulse counts down from its length; the last count frees the cpu
   // limitation: a kick that lands during the pulse rearms at once
   assign pulse_last = (pulse_q == {{(`WD_RST_CNT_W-1){1'b0}}, 1'b1});

   always @* begin
      pulse_d     = pulse_q;
      cpu_rst_n_d = 1'b1;
      if (expire) begin
         pulse_d     = `WD_RST_PULSE_CYC; // R03
         cpu_rst_n_d = 1'b0; // R03
      end else if (pulse_q != {`WD_RST_CNT_W{1'b0}}) begin
         pulse_d     = pulse_q - 1'b1;
         cpu_rst_n_d = pulse_last;
      end
   end

   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pulse_q   <= {`WD_RST_CNT_W{1'b0}};
         cpu_rst_n <= 1'b1;
      end else begin
         pulse_q   <= pulse_d;
         cpu_rst_n <= cpu_rst_n_d;
      end
   end

   // ****************************************************************
   // read data: the value carries nothing, only the cycle counts
   // ****************************************************************
   // the enable trails the pin by three edges: the synchroniser's two and its own flop
   // a fixed value exposes no state, so a stray read learns nothing
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rd_data    <= `WD_RD_DATA_RST;
         rd_data_oe <= 1'b0;
      end else begin
         rd_data    <= `WD_RD_DATA; // R07
         rd_data_oe <= rd_s & port_hit;
      end
   end
endmodule

// [bench/host_rd_model.sv]
// host cpu model: issues single i/o port reads
// assumes the bench calls rd only after reset is released
`timescale 1ns/100ps
module host_rd_model (
   input wire logic clk_sys,
   output logic io_rd_n,
   output logic [15:0] io_addr);
   initial {io_rd_n, io_addr} = {1'b1, 16'hffff};
   // address flipped on release so no stale value lingers
   task automatic rd(input logic [15:0] a);
      @(posedge clk_sys);
      {io_rd_n, io_addr} <= {1'b0, a};
      repeat (4) @(posedge clk_sys);
      {io_rd_n, io_addr} <= {1'b1, ~a};
      repeat (4) @(posedge clk_sys);
   endtask
endmodule

// [bench/io_read_watchdog_asserts.sv]
// checker on the io_read_watchdog ports
// assumes one clock and an async active low reset
`timescale 1ns/100ps
module io_read_watchdog_asserts #(parameter [27:0] TIMEOUT_CYC = 28'h000_0032) (
   input wire logic clk_sys, nrst, io_rd_n, cpu_rst_n, armed, rd_data_oe,
   input wire logic [15:0] io_addr,
   input wire logic [7:0] rd_data);
   logic [27:0] idle_q;
   logic oe_q;
   // cycles since a watchdog port read began
   always @(posedge clk_sys or negedge nrst)
      if (!nrst) {idle_q, oe_q} <= '0;
      else {idle_q, oe_q} <= {(rd_data_oe && !oe_q) ? 28'h000_0000 : idle_q + 28'h000_0001,
                              rd_data_oe};
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   property p_arm; $rose(armed) |-> $past(io_addr, 2) == 16'h0443; endproperty
   a_arm: assert property (p_arm) else $error("arm w/o kick");
   property p_restart; $fell(cpu_rst_n) |-> idle_q >= TIMEOUT_CYC - 28'h4; endproperty
   a_restart: assert property (p_restart) else $error("early reset");
   property p_expire; armed && $past(armed) |-> idle_q <= TIMEOUT_CYC; endproperty
   a_expire: assert property (p_expire) else $error("no reset");
   property p_pulse; $fell(cpu_rst_n) |-> !cpu_rst_n[*8] ##1 !cpu_rst_n[*8] ##1 cpu_rst_n;
   endproperty
   a_pulse: assert property (p_pulse) else $error("bad pulse");
   property p_stop; $fell(armed) |-> $past(io_addr, 2) == 16'h0043 || !cpu_rst_n; endproperty
   a_stop: assert property (p_stop) else $error("bad disarm");
   property p_tol; $fell(cpu_rst_n) |-> idle_q * 10 <= TIMEOUT_CYC * 13; endproperty
   a_tol: assert property (p_tol) else $error("late reset");
   property p_data; rd_data_oe |-> rd_data == 8'hff; endproperty
   a_data: assert property (p_data) else $error("bad data");
   c_arm: cover property ($rose(armed));
   c_fire: cover property ($fell(cpu_rst_n));
   c_stop: cover property ($fell(armed) && cpu_rst_n);
endmodule

// [bench/test_io_read_watchdog.sv]
// self-checking bench for io_read_watchdog
// assumes host_rd_model drives strobe and address
`timescale 1ns/100ps
module test_io_read_watchdog;
   localparam logic [27:0] T = 28'h000_0032; // short stand-in for 1.6 s
   logic clk_sys, nrst, io_rd_n, cpu_rst_n, armed, rd_data_oe;
   logic [15:0] io_addr;
   logic [7:0] rd_data;
   int miscompares, n_tests, cyc, n;
   io_read_watchdog #(.TIMEOUT_CYC(T)) dut_u (.clk_sys(clk_sys), .nrst(nrst),
      .io_rd_n(io_rd_n), .io_addr(io_addr), .cpu_rst_n(cpu_rst_n), .armed(armed),
      .rd_data(rd_data), .rd_data_oe(rd_data_oe));
   host_rd_model host_u (.clk_sys(clk_sys), .io_rd_n(io_rd_n), .io_addr(io_addr));
   task automatic chk(input logic [7:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic t_arm;
      host_u.rd(16'h0043);
      chk(armed, 8'h00);
      host_u.rd(16'h1443);
      chk(armed, 8'h00);
      host_u.rd(16'h0443);
      chk(armed, 8'h01);
      chk(rd_data, 8'hff);
   endtask
   task automatic t_kick;
      // total span outlasts one timeout, so an ignored kick shows as a pulse
      repeat (3) begin
         repeat (30) begin
            @(posedge clk_sys);
            #1 chk(cpu_rst_n, 8'h01);
         end
         host_u.rd(16'h0443);
      end
      chk(armed, 8'h01);
   endtask
   task automatic t_fire;
      n = 0;
      while (cpu_rst_n !== 1'b0 && n < 200) begin
         @(posedge clk_sys);
         #1 n++;
      end
      // n starts five edges after the last kick took effect
      chk(8'(n + 5 >= T * 7 / 10 && n + 5 <= T * 13 / 10), 8'h01);
      chk(armed, 8'h00);
      repeat (15) @(posedge clk_sys);
      #1 chk(cpu_rst_n, 8'h00);
      @(posedge clk_sys);
      #1 chk(cpu_rst_n, 8'h01);
   endtask
   task automatic t_stop;
      host_u.rd(16'h0443);
      chk(armed, 8'h01);
      host_u.rd(16'h0043);
      chk(armed, 8'h00);
      repeat (100) begin
         @(posedge clk_sys);
         #1 chk(cpu_rst_n, 8'h01);
      end
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      nrst = 1'b0;
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      t_arm;
      t_kick;
      t_fire;
      t_stop;
      close_out;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         close_out;
      end
   end
endmodule
bind io_read_watchdog io_read_watchdog_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_u (
   .clk_sys(clk_sys), .nrst(nrst), .io_rd_n(io_rd_n), .cpu_rst_n(cpu_rst_n),
   .armed(armed), .rd_data_oe(rd_data_oe), .io_addr(io_addr), .rd_data(rd_data));
